/* File: design/usbirq_force_status.sv */
// Interrupt force, mask and masked-status logic of a USB controller, AXI4-Lite slave.
// Assumes all event, level and clear inputs come from logic on aclk.
// Overview of operation
// - Masked status word is raw OR force, ANDed with mask; read-only.
// - Bit 19 is high while any per-endpoint refusal flag is set.
// - Bit 18 is high while any per-endpoint abort-completed flag is set.
// - Device role frame start sets bit 17; frame number read clears it.
// - Host resume sets bit 15; resume flag write clears it.
// - Suspend state change sets bit 14; link_idle_state flag write clears it.
// - Connection state change sets bit 13; connected flag write clears it.
// - Bit 4 is high while any per-endpoint buffer-done flag is set.
// - Transaction finished sets bit 3; writing one to that bit clears it.
// - Host role frame transmit sets bit 2; frame number read clears it.
// - Host role remote wake sets bit 1; resume flag write clears it.
// - Host role speed field change sets bit 0; speed field write clears it.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
module usbirq_force_status #(
  parameter int NUM_EP_FLAGS = 32
) (
  input wire logic aclk, // Register clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [usbirq_pkg::ADDR_W-1:0] awaddr, // Write byte address.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  input wire logic [usbirq_pkg::DATA_W-1:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write byte strobes.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  output logic [1:0] bresp, // Write response code.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  input wire logic [usbirq_pkg::ADDR_W-1:0] araddr, // Read byte address.
  output logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  output logic [usbirq_pkg::DATA_W-1:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response code.
  input wire logic host_mode, // High in host role, low in device role.
  input wire logic [NUM_EP_FLAGS-1:0] per_endpoint_refusal_flags, // Stall or NAK flags.
  input wire logic [NUM_EP_FLAGS-1:0] abort_done_flags, // Abort-completed flags.
  input wire logic [NUM_EP_FLAGS-1:0] buffer_done_flags, // Buffer-done flags.
  input wire usbirq_pkg::usbirq_mirror_type mirror_flags, // Copied status flags.
  input wire usbirq_pkg::usbirq_pulse_type event_pulses, // Event pulses.
  input wire usbirq_pkg::usbirq_clear_type clear_pulses, // Clear pulses.
  input wire logic link_idle_state, // Device suspend state level.
  input wire logic device_attached, // Device connection state level.
  input wire logic [1:0] line_speed, // Detected line speed field.
  output logic irq // Level interrupt to the processor.
);

  // Elaboration check: the flag vectors are sized for at most one 32-bit word.
  if (NUM_EP_FLAGS < 1 || NUM_EP_FLAGS > 32) begin : g_ep_range
    $error("NUM_EP_FLAGS must lie between 1 and 32.");
  end

  // All state of the block.
  typedef struct packed {
    logic [19:0] mask;
    logic [19:0] force_bits;
    logic [19:0] sticky;
    logic prev_sleep;
    logic prev_attach;
    logic [1:0] prev_speed;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } usbirq_state_type;

  usbirq_state_type st_q;
  usbirq_state_type st_d;
  logic [19:0] level_v;
  logic [19:0] raw_v;
  logic [19:0] mstat_v;
  logic [19:0] set_v;
  logic [19:0] clr_v;
  logic [8:0] mirror_bits;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_take;

  // Byte-lane merge of a 20-bit register; lanes above bit 19 have nothing to hold.
  function automatic logic [19:0] merge20(input logic [19:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [19:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    if (strb[2]) begin
      res[19:16] = data[19:16];
    end
    return res;
  endfunction : merge20

  // Handshake readies are free while nothing is held and no answer is pending.
  assign awready = !st_q.aw_have && !st_q.bvalid;
  assign wready = !st_q.w_have && !st_q.bvalid;
  assign arready = !st_q.rvalid;
  assign bvalid = st_q.bvalid;
  assign bresp = st_q.bresp;
  assign rvalid = st_q.rvalid;
  assign rdata = st_q.rdata;
  assign rresp = st_q.rresp;

  // Level events follow their sources with no latch, so they fall as soon as
  // software has cleared the last flag behind them.
  assign mirror_bits = mirror_flags;
  always_comb begin
    level_v = usbirq_pkg::EVT_RESET;
    level_v[usbirq_pkg::BIT_REFUSAL] = |per_endpoint_refusal_flags;
    level_v[usbirq_pkg::BIT_ABORT] = |abort_done_flags;
    level_v[usbirq_pkg::BIT_BUFFER] = |buffer_done_flags;
    level_v[usbirq_pkg::BIT_SETUP] = mirror_bits[8];
    level_v[usbirq_pkg::BIT_MIRROR_HI:usbirq_pkg::BIT_MIRROR_LO] = mirror_bits[7:0];
  end

  // Raw, forced and masked views; the interrupt is the OR of the masked view.
  assign raw_v = st_q.sticky | level_v;
  assign mstat_v = (raw_v | st_q.force_bits) & st_q.mask;
  assign irq = |mstat_v;

  // Write request: a held half or the one offered now.
  assign wr_addr = st_q.aw_have ? st_q.aw_addr : awaddr;
  assign wr_data = st_q.w_have ? st_q.w_data : wdata;
  assign wr_strb = st_q.w_have ? st_q.w_strb : wstrb;
  assign wr_fire = (st_q.aw_have || awvalid) && (st_q.w_have || wvalid) && !st_q.bvalid;
  assign rd_take = arvalid && arready;

  // Set sources of the latched event bits; role gating covers bits 17 and 2 to 0 only, bits 15 to 13 set in either role.
  always_comb begin
    set_v = usbirq_pkg::EVT_RESET;
    set_v[usbirq_pkg::BIT_DEVICE_FRAME_START_EVENT] = event_pulses.device_frame_start && !host_mode;
    set_v[usbirq_pkg::BIT_DEV_WAKE] = event_pulses.device_wake;
    set_v[usbirq_pkg::BIT_DEV_SLEEP] = link_idle_state != st_q.prev_sleep;
    set_v[usbirq_pkg::BIT_DEV_ATTACH] = device_attached != st_q.prev_attach;
    set_v[usbirq_pkg::BIT_TRANS] = event_pulses.transaction_finished;
    set_v[usbirq_pkg::BIT_HOST_SOF] = event_pulses.host_frame_start && host_mode;
    set_v[usbirq_pkg::BIT_HOST_WAKE] = event_pulses.host_remote_wake && host_mode;
    set_v[usbirq_pkg::BIT_HOST_ATTACH] = (line_speed != st_q.prev_speed) && host_mode;
  end

  // Clear sources; the write-one clear of bit 3 needs its byte lane enabled.
  always_comb begin
    clr_v = usbirq_pkg::EVT_RESET;
    clr_v[usbirq_pkg::BIT_DEVICE_FRAME_START_EVENT] = clear_pulses.frame_number_read;
    clr_v[usbirq_pkg::BIT_DEV_WAKE] = clear_pulses.resume_flag_write;
    clr_v[usbirq_pkg::BIT_DEV_SLEEP] = clear_pulses.sleep_flag_write;
    clr_v[usbirq_pkg::BIT_DEV_ATTACH] = clear_pulses.attach_flag_write;
    clr_v[usbirq_pkg::BIT_TRANS] = wr_fire && wr_addr == usbirq_pkg::OFF_RAW && wr_strb[0]
                                   && wr_data[usbirq_pkg::BIT_TRANS];
    clr_v[usbirq_pkg::BIT_HOST_SOF] = clear_pulses.frame_number_read;
    clr_v[usbirq_pkg::BIT_HOST_WAKE] = clear_pulses.resume_flag_write;
    clr_v[usbirq_pkg::BIT_HOST_ATTACH] = clear_pulses.speed_field_write;
  end

  // Next state: the set term is ORed after the clear so an event in the clear
  // cycle survives.
  always_comb begin
    st_d = st_q;
    st_d.sticky = ((st_q.sticky & ~clr_v) | set_v) & usbirq_pkg::STICKY_BITS;
    st_d.prev_sleep = link_idle_state;
    st_d.prev_attach = device_attached;
    st_d.prev_speed = line_speed;
    if (st_q.bvalid && bready) begin
      st_d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = usbirq_pkg::RESP_OKAY;
      case (wr_addr)
        usbirq_pkg::OFF_MASK: begin
          st_d.mask = merge20(st_q.mask, wr_data, wr_strb);
        end
        usbirq_pkg::OFF_FORCE: begin
          st_d.force_bits = merge20(st_q.force_bits, wr_data, wr_strb);
        end
        usbirq_pkg::OFF_RAW: begin
          st_d.bresp = usbirq_pkg::RESP_OKAY;
        end
        usbirq_pkg::OFF_MSTAT: begin
          st_d.bresp = usbirq_pkg::RESP_OKAY;
        end
        default: begin
          st_d.bresp = usbirq_pkg::RESP_SLVERR;
        end
      endcase
    end else begin
      if (awvalid && awready) begin
        st_d.aw_have = 1'b1;
        st_d.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
        st_d.w_have = 1'b1;
        st_d.w_data = wdata;
        st_d.w_strb = wstrb;
      end
    end
    if (st_q.rvalid && rready) begin
      st_d.rvalid = 1'b0;
    end
    if (rd_take) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = usbirq_pkg::RESP_OKAY;
      case (araddr)
        usbirq_pkg::OFF_MASK: begin
          st_d.rdata = {usbirq_pkg::UPPER_ZERO, st_q.mask};
        end
        usbirq_pkg::OFF_FORCE: begin
          st_d.rdata = {usbirq_pkg::UPPER_ZERO, st_q.force_bits};
        end
        usbirq_pkg::OFF_RAW: begin
          st_d.rdata = {usbirq_pkg::UPPER_ZERO, raw_v};
        end
        usbirq_pkg::OFF_MSTAT: begin
          st_d.rdata = {usbirq_pkg::UPPER_ZERO, mstat_v};
        end
        default: begin
          st_d.rdata = {usbirq_pkg::UPPER_ZERO, usbirq_pkg::EVT_RESET};
          st_d.rresp = usbirq_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // State register; reset loads constants only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  default clocking chk_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_mstat_read: assert property (
    rd_take && araddr == usbirq_pkg::OFF_MSTAT |=> rvalid && rdata[19:0] == $past(mstat_v))
    else $error("Masked status read does not match raw, force and mask.");

  chk_irq_level: assert property (
    rd_take && araddr == usbirq_pkg::OFF_MSTAT |=> (rdata[19:0] != 20'h00000) == $past(irq))
    else $error("Interrupt output disagrees with masked status.");

  chk_refusal_level: assert property (
    raw_v[usbirq_pkg::BIT_REFUSAL] == |per_endpoint_refusal_flags)
    else $error("Refusal event does not follow the endpoint flags.");

  chk_abort_level: assert property (
    $fell(|abort_done_flags) |-> !raw_v[usbirq_pkg::BIT_ABORT])
    else $error("Abort event outlived its flags.");

  chk_dev_frame_set: assert property (
    event_pulses.device_frame_start && !host_mode |=> raw_v[usbirq_pkg::BIT_DEVICE_FRAME_START_EVENT])
    else $error("Device frame start did not set its event.");

  chk_frame_clear: assert property (
    clear_pulses.frame_number_read && !set_v[usbirq_pkg::BIT_DEVICE_FRAME_START_EVENT]
    && !set_v[usbirq_pkg::BIT_HOST_SOF]
    |=> !raw_v[usbirq_pkg::BIT_DEVICE_FRAME_START_EVENT] && !raw_v[usbirq_pkg::BIT_HOST_SOF])
    else $error("Frame number read did not clear frame events.");

  chk_wake_hold: assert property (
    event_pulses.device_wake ##1 !clear_pulses.resume_flag_write
    |=> raw_v[usbirq_pkg::BIT_DEV_WAKE])
    else $error("Device wake event did not hold until cleared.");

  chk_sleep_change: assert property (
    $changed(link_idle_state) |=> raw_v[usbirq_pkg::BIT_DEV_SLEEP])
    else $error("Suspend change did not set its event.");

  chk_attach_change: assert property (
    $changed(device_attached) |=> raw_v[usbirq_pkg::BIT_DEV_ATTACH])
    else $error("Connection change did not set its event.");

  chk_buffer_level: assert property (
    raw_v[usbirq_pkg::BIT_BUFFER] == |buffer_done_flags)
    else $error("Buffer event does not follow the buffer flags.");

  chk_trans_w1c: assert property (
    clr_v[usbirq_pkg::BIT_TRANS] && !event_pulses.transaction_finished
    |=> !raw_v[usbirq_pkg::BIT_TRANS] && bvalid)
    else $error("Write of one did not clear the transaction event.");

  chk_host_gate: assert property (
    !host_mode && !st_q.sticky[usbirq_pkg::BIT_HOST_SOF] |=> !st_q.sticky[usbirq_pkg::BIT_HOST_SOF])
    else $error("Host frame event rose in device role.");

  chk_host_wake: assert property (
    event_pulses.host_remote_wake && host_mode |=> raw_v[usbirq_pkg::BIT_HOST_WAKE])
    else $error("Remote wake did not set its event.");

  chk_speed_change: assert property (
    host_mode && $changed(line_speed) |=> raw_v[usbirq_pkg::BIT_HOST_ATTACH])
    else $error("Speed change did not set the host attach event.");

  chk_mirror_copy: assert property (
    raw_v[usbirq_pkg::BIT_MIRROR_HI:usbirq_pkg::BIT_MIRROR_LO] == mirror_bits[7:0])
    else $error("Mirrored flags do not reach their event bits.");

  chk_upper_zero: assert property (
    rvalid |-> rdata[31:20] == usbirq_pkg::UPPER_ZERO)
    else $error("Upper bits of a read are not zero.");

  chk_mstat_readonly: assert property (
    wr_fire && wr_addr == usbirq_pkg::OFF_MSTAT
    |=> bvalid && bresp == usbirq_pkg::RESP_OKAY && $stable(st_q.mask)
    && $stable(st_q.force_bits))
    else $error("Write to the masked status word changed state or failed.");

  chk_dev_frame_gate: assert property (
    host_mode && !st_q.sticky[usbirq_pkg::BIT_DEVICE_FRAME_START_EVENT]
    |=> !st_q.sticky[usbirq_pkg::BIT_DEVICE_FRAME_START_EVENT])
    else $error("Device frame event rose in host role.");

  chk_speed_gate: assert property (
    !host_mode && !st_q.sticky[usbirq_pkg::BIT_HOST_ATTACH]
    |=> !st_q.sticky[usbirq_pkg::BIT_HOST_ATTACH])
    else $error("Speed event rose in device role.");

  // Reset itself is what this check watches, so it must not be disabled by it.
  chk_reset_zero: assert property (
    disable iff (1'b0) !aresetn |=> st_q.sticky == 20'h00000 && st_q.force_bits == 20'h00000
    && !irq)
    else $error("Reset left an event, a force bit or the interrupt set.");

  cov_irq_rise: cover property ($rose(irq));
  cov_forced_irq: cover property (st_q.force_bits != 20'h00000 && irq);
  cov_mstat_read: cover property (rd_take && araddr == usbirq_pkg::OFF_MSTAT ##1 rvalid);
  cov_set_on_clear: cover property (set_v[usbirq_pkg::BIT_DEVICE_FRAME_START_EVENT] && clr_v[usbirq_pkg::BIT_DEVICE_FRAME_START_EVENT]);

endmodule : usbirq_force_status

/* File: design/usbirq_pkg.sv */
// Shared constants and carrier types of the interrupt force and masked-status block.
// Assumes a 32-bit AXI4-Lite register bus and a link engine on the same clock.
package usbirq_pkg;

  // Bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int EVT_W = 20;

  // Register byte offsets.
  localparam logic [7:0] OFF_RAW = 8'h8c;
  localparam logic [7:0] OFF_MASK = 8'h90;
  localparam logic [7:0] OFF_FORCE = 8'h94;
  localparam logic [7:0] OFF_MSTAT = 8'h98;

  // Reset values and the set of bits that latch until cleared.
  localparam logic [19:0] EVT_RESET = 20'h00000;
  localparam logic [19:0] STICKY_BITS = 20'h2e00f;
  localparam logic [11:0] UPPER_ZERO = 12'h000;

  // Event bit positions.
  localparam int BIT_REFUSAL = 19;
  localparam int BIT_ABORT = 18;
  localparam int BIT_DEVICE_FRAME_START_EVENT = 17;
  localparam int BIT_SETUP = 16;
  localparam int BIT_DEV_WAKE = 15;
  localparam int BIT_DEV_SLEEP = 14;
  localparam int BIT_DEV_ATTACH = 13;
  localparam int BIT_MIRROR_HI = 12;
  localparam int BIT_MIRROR_LO = 5;
  localparam int BIT_BUFFER = 4;
  localparam int BIT_TRANS = 3;
  localparam int BIT_HOST_SOF = 2;
  localparam int BIT_HOST_WAKE = 1;
  localparam int BIT_HOST_ATTACH = 0;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Status flags of the link engine that are copied straight through, msb first.
  typedef struct packed {
    logic control_packet_received;
    logic line_reset;
    logic supply_present_flag;
    logic halt_handshake_received;
    logic crc_error;
    logic stuffing_fault_flag;
    logic rx_overflow;
    logic rx_timeout;
    logic toggle_mismatch_flag;
  } usbirq_mirror_type;

  // One-cycle event pulses from the link engine.
  typedef struct packed {
    logic device_frame_start;
    logic device_wake;
    logic transaction_finished;
    logic host_frame_start;
    logic host_remote_wake;
  } usbirq_pulse_type;

  // One-cycle clear pulses from the surrounding register file.
  typedef struct packed {
    logic frame_number_read;
    logic resume_flag_write;
    logic sleep_flag_write;
    logic attach_flag_write;
    logic speed_field_write;
  } usbirq_clear_type;

endpackage : usbirq_pkg

/* File: tb/usbirq_intc_model.sv */
// Model of the processor interrupt controller that watches the block's interrupt line.
// Assumes irq is a level on aclk and ack is a one-cycle software pulse on aclk.
module usbirq_intc_model (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic irq, // Level interrupt from the block.
  input wire logic ack, // Software acknowledge pulse.
  output logic pending // Request as seen by the processor.
);
  timeunit 1ns;
  timeprecision 1ps;
  // A live level keeps the request pending, so an ack cannot hide it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending <= 1'b0;
    end else begin
      pending <= irq | (pending & ~ack);
    end
  end
endmodule : usbirq_intc_model

/* File: tb/usb_irq_force_status_bench.sv */
// Self-checking bench of the interrupt force and masked-status block.
// Assumes the design package is compiled first and the interrupt model beside it.
module usb_irq_force_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NEP = 8;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ack;
  logic awready, wready, bvalid, arready, rvalid, irq, pending;
  logic host_mode, idle, attached;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, speed;
  logic [NEP-1:0] refusal, aborts, bufs;
  logic [8:0] mirror;
  logic [4:0] pulses, clears;
  int err_count, comparisons;

  usbirq_force_status #(.NUM_EP_FLAGS(NEP)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .host_mode(host_mode),
    .per_endpoint_refusal_flags(refusal), .abort_done_flags(aborts),
    .buffer_done_flags(bufs), .mirror_flags(mirror), .event_pulses(pulses),
    .clear_pulses(clears), .link_idle_state(idle), .device_attached(attached),
    .line_speed(speed), .irq(irq));

  usbirq_intc_model intc_u (.aclk(aclk), .aresetn(aresetn), .irq(irq), .ack(ack),
    .pending(pending));

  // Clock of 100 MHz.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_word(nm, {31'h0, e}, {31'h0, g});
  endtask : chk_bit

  task automatic finish_test();
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  // Each channel stands until the edge that takes it; readies are looked at mid-cycle.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_go, w_go;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      @(posedge aclk);
      if (aw_go) begin
        awvalid <= 1'b0;
      end
      if (w_go) begin
        wvalid <= 1'b0;
      end
    end while ((awvalid && !aw_go) || (wvalid && !w_go));
    do @(negedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    chk_word("rdata", e, rdata);
    chk_word("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd_chk

  task automatic clr(input int c);
    @(posedge aclk);
    clears[c] <= 1'b1;
    @(posedge aclk);
    clears <= 5'h0;
  endtask : clr

  task automatic t_reset();
    logic [1:0] r;
    rd_chk(usbirq_pkg::OFF_FORCE, 32'h0, usbirq_pkg::RESP_OKAY);
    rd_chk(usbirq_pkg::OFF_MSTAT, 32'h0, usbirq_pkg::RESP_OKAY);
    rd_chk(8'h00, 32'h0, usbirq_pkg::RESP_SLVERR);
    axi_wr(8'h04, 32'h1, r);
    chk_word("bresp", 32'h2, {30'h0, r});
    @(negedge aclk);
    chk_bit("irq", 1'b0, irq);
  endtask : t_reset

  task automatic t_force();
    logic [1:0] r;
    axi_wr(usbirq_pkg::OFF_MASK, 32'hffffffff, r);
    axi_wr(usbirq_pkg::OFF_FORCE, 32'hffffffff, r);
    rd_chk(usbirq_pkg::OFF_FORCE, 32'h000fffff, usbirq_pkg::RESP_OKAY);
    rd_chk(usbirq_pkg::OFF_MSTAT, 32'h000fffff, usbirq_pkg::RESP_OKAY);
    @(negedge aclk);
    chk_bit("pending", 1'b1, pending);
    // The status word ignores writes.
    axi_wr(usbirq_pkg::OFF_MSTAT, 32'h0, r);
    rd_chk(usbirq_pkg::OFF_MSTAT, 32'h000fffff, usbirq_pkg::RESP_OKAY);
    axi_wr(usbirq_pkg::OFF_MASK, 32'h00000005, r);
    rd_chk(usbirq_pkg::OFF_MSTAT, 32'h00000005, usbirq_pkg::RESP_OKAY);
    axi_wr(usbirq_pkg::OFF_MASK, 32'h0, r);
    @(posedge aclk);
    ack <= 1'b1;
    @(posedge aclk);
    ack <= 1'b0;
    @(negedge aclk);
    chk_bit("irq", 1'b0, irq);
    chk_bit("pending", 1'b0, pending);
    axi_wr(usbirq_pkg::OFF_FORCE, 32'h0, r);
    axi_wr(usbirq_pkg::OFF_MASK, 32'h000fffff, r);
  endtask : t_force

  // A reset in mid-run must drop force, mask and every latched event.
  task automatic t_midreset();
    logic [1:0] r;
    axi_wr(usbirq_pkg::OFF_FORCE, 32'h00000f0f, r);
    @(posedge aclk);
    pulses[2] <= 1'b1;
    @(posedge aclk);
    pulses <= 5'h0;
    rd_chk(usbirq_pkg::OFF_RAW, 32'h00000008, usbirq_pkg::RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(usbirq_pkg::OFF_FORCE, 32'h0, usbirq_pkg::RESP_OKAY);
    rd_chk(usbirq_pkg::OFF_RAW, 32'h0, usbirq_pkg::RESP_OKAY);
    rd_chk(usbirq_pkg::OFF_MASK, 32'h0, usbirq_pkg::RESP_OKAY);
    @(negedge aclk);
    chk_bit("irq after reset", 1'b0, irq);
    chk_bit("pending after reset", 1'b0, pending);
    axi_wr(usbirq_pkg::OFF_MASK, 32'h000fffff, r);
  endtask : t_midreset

  task automatic lv(input logic [NEP-1:0] f, a, b, input logic [8:0] m, input logic [31:0] e);
    @(posedge aclk);
    refusal <= f;
    aborts <= a;
    bufs <= b;
    mirror <= m;
    rd_chk(usbirq_pkg::OFF_MSTAT, e, usbirq_pkg::RESP_OKAY);
  endtask : lv

  task automatic t_levels();
    lv(8'h21, 8'h0, 8'h0, 9'h0, 32'h80000);
    lv(8'h01, 8'h0, 8'h0, 9'h0, 32'h80000);
    lv(8'h00, 8'h81, 8'h0, 9'h0, 32'h40000);
    lv(8'h00, 8'h00, 8'h80, 9'h0, 32'h00010);
    lv(8'h00, 8'h00, 8'h00, 9'h1ff, 32'h11fe0);
    lv(8'h00, 8'h00, 8'h00, 9'h101, 32'h10020);
    lv(8'h00, 8'h00, 8'h00, 9'h0, 32'h0);
  endtask : t_levels

  // A negative clear index means the write-one clear of the raw word.
  task automatic ev(input int p, input int c, input logic hm, input logic [31:0] e);
    logic [1:0] r;
    @(posedge aclk);
    host_mode <= hm;
    @(posedge aclk);
    pulses[p] <= 1'b1;
    @(posedge aclk);
    pulses <= 5'h0;
    rd_chk(usbirq_pkg::OFF_MSTAT, e, usbirq_pkg::RESP_OKAY);
    if (c < 0) begin
      axi_wr(usbirq_pkg::OFF_RAW, 32'h8, r);
    end else begin
      clr(c);
    end
    rd_chk(usbirq_pkg::OFF_MSTAT, 32'h0, usbirq_pkg::RESP_OKAY);
  endtask : ev

  task automatic t_events();
    ev(4, 4, 1'b0, 32'h20000);
    ev(4, 4, 1'b1, 32'h0);
    ev(3, 3, 1'b0, 32'h08000);
    ev(2, -1, 1'b0, 32'h00008);
    ev(1, 4, 1'b1, 32'h00004);
    ev(0, 3, 1'b1, 32'h00002);
    ev(0, 3, 1'b0, 32'h0);
  endtask : t_events

  task automatic t_changes();
    @(posedge aclk);
    host_mode <= 1'b0;
    idle <= 1'b1;
    // A speed change in device role must leave bit 0 low.
    speed <= 2'h1;
    rd_chk(usbirq_pkg::OFF_MSTAT, 32'h04000, usbirq_pkg::RESP_OKAY);
    clr(2);
    idle <= 1'b0;
    rd_chk(usbirq_pkg::OFF_MSTAT, 32'h04000, usbirq_pkg::RESP_OKAY);
    clr(2);
    attached <= 1'b1;
    rd_chk(usbirq_pkg::OFF_MSTAT, 32'h02000, usbirq_pkg::RESP_OKAY);
    clr(1);
    host_mode <= 1'b1;
    speed <= 2'h2;
    rd_chk(usbirq_pkg::OFF_MSTAT, 32'h00001, usbirq_pkg::RESP_OKAY);
    clr(0);
    rd_chk(usbirq_pkg::OFF_MSTAT, 32'h0, usbirq_pkg::RESP_OKAY);
  endtask : t_changes

  // Cuts a hang short well after the expected run of a few hundred cycles.
  initial begin
    #200us;
    err_count++;
    finish_test();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ack} = 7'h0;
    {host_mode, idle, attached, speed} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    {refusal, aborts, bufs, mirror, pulses, clears} = '0;
    err_count = 0;
    comparisons = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_force();
    t_midreset();
    t_levels();
    t_events();
    t_changes();
    finish_test();
  end
endmodule : usb_irq_force_status_bench
